// >>> logic/sop_core.sv
// Serial program and verify engine: link-side shifter and system-side programming.
`timescale 1ns/1ps
`include "sop_cfg.svh"
module sop_core
  import sop_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic prog_clock_pin_in,
  input  wire logic prog_data_pin_in,
  output logic      prog_data_pin_out,
  output logic      prog_data_pin_oe_out,
  output logic      prog_active_out,
  output logic      hv_discharge_out
);
  // Link domain, clocked by the programmer's serial clock.
  // The data pin is launched by the programmer on this same clock, so it
  // is sampled directly; reset and the acknowledges are synchronized in, and the read byte is taken once acknowledged.
  logic        lrst_meta, lrst_reg;
  sop_lst_t    lst_reg;
  logic [3:0]  cnt_reg;
  logic [15:0] sh_reg;
  logic [3:0]  op_reg;
  logic [21:0] ptr_reg;
  logic [7:0]  latch_reg;
  logic        wtog_reg, rtog_reg;
  sop_wreq_t   wreq_reg;
  sop_rreq_t   rreq_reg;
  logic        wack_meta, wack_s, rack_meta, rack_s;
  logic        wack_reg, rack_reg;
  logic        dout_reg, doe_reg;
  logic [3:0]  op_w;
  logic [1:0]  mode_w;
  logic [21:0] ptr_pre, ptr_post;
  logic        wr_pend, fetch_end, tbl_op, wr_op;
  logic [7:0]  rd_byte_reg;

  always_ff @(posedge prog_clock_pin_in) begin
    lrst_meta <= reset_in;
    lrst_reg  <= lrst_meta;
    wack_meta <= wack_reg;
    wack_s    <= wack_meta;
    rack_meta <= rack_reg;
    rack_s    <= rack_meta;
  end

  assign op_w      = {prog_data_pin_in, sh_reg[15:13]};
  assign mode_w    = op_w[1:0];
  assign tbl_op    = op_w[`SOP_OP_TBL_BIT];
  assign wr_op     = op_w[`SOP_OP_WR_BIT];
  assign wr_pend   = wtog_reg != wack_s;
  assign fetch_end = lst_reg == L_FETCH && cnt_reg == 4'h3;
  assign ptr_pre   = (mode_w == `SOP_MODE_PRE) ? ptr_reg + 22'h1 : ptr_reg;
  always_comb begin
    ptr_post = ptr_reg;
    if (op_reg[1:0] == `SOP_MODE_INC)
      ptr_post = ptr_reg + 22'h1;
    else if (op_reg[1:0] == `SOP_MODE_DEC)
      ptr_post = ptr_reg - 22'h1;
  end

  // Serial shifter, least significant bit first.
  always_ff @(posedge prog_clock_pin_in) begin
    if (lrst_reg)
      sh_reg <= 16'h0000;
    else
      sh_reg <= {prog_data_pin_in, sh_reg[15:1]};
  end

  always_ff @(posedge prog_clock_pin_in) begin
    if (lrst_reg) begin
      lst_reg <= L_FETCH;
      cnt_reg <= 4'h0;
      op_reg  <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      case (lst_reg)
        L_FETCH: begin
          if (cnt_reg == 4'h3) begin
            cnt_reg <= 4'h0;
            op_reg  <= op_w;
            if (tbl_op && wr_op && !wr_pend)
              lst_reg <= L_WDATA;
            else if (tbl_op && !wr_op)
              lst_reg <= L_REXEC;
            else if (op_w == `SOP_OP_LDL || op_w == `SOP_OP_LDH || op_w == `SOP_OP_LDU)
              lst_reg <= L_LOAD;
          end
        end
        L_LOAD: begin
          if (cnt_reg == 4'h7) begin
            cnt_reg <= 4'h0;
            lst_reg <= L_FETCH;
          end
        end
        L_WDATA: begin
          if (cnt_reg == 4'hf)
            lst_reg <= L_FETCH;
        end
        L_REXEC: begin
          if (cnt_reg == 4'h7) begin
            cnt_reg <= 4'h0;
            lst_reg <= L_ROUT;
          end
        end
        L_ROUT: begin
          if (cnt_reg == 4'h7) begin
            cnt_reg <= 4'h0;
            lst_reg <= L_FETCH;
          end
        end
        default: begin
          cnt_reg <= 4'h0;
          lst_reg <= L_FETCH;
        end
      endcase
    end
  end

  // Table pointer: byte loads, pre-increment at decode, post-update at end.
  always_ff @(posedge prog_clock_pin_in) begin
    if (lrst_reg)
      ptr_reg <= 22'h000000;
    else if (fetch_end && tbl_op && !(wr_op && wr_pend))
      ptr_reg <= ptr_pre;
    else if (lst_reg == L_LOAD && cnt_reg == 4'h7) begin
      if (op_reg == `SOP_OP_LDL)
        ptr_reg[7:0] <= {prog_data_pin_in, sh_reg[15:9]};
      else if (op_reg == `SOP_OP_LDH)
        ptr_reg[15:8] <= {prog_data_pin_in, sh_reg[15:9]};
      else
        // The two low bits of the upper byte land on the top pointer bits,
        // so an upper byte of 03h opens the test and configuration space.
        ptr_reg[21:16] <= {sh_reg[10:9], sh_reg[14:11]};
    end else if ((lst_reg == L_WDATA && cnt_reg == 4'hf) ||
                 (lst_reg == L_REXEC && cnt_reg == 4'h7))
      ptr_reg <= ptr_post;
  end

  // Requests to the system side, handed over by toggle; a write request is held until acknowledged, a read request until the next read.
  always_ff @(posedge prog_clock_pin_in) begin
    if (lrst_reg) begin
      wtog_reg <= 1'b0;
      rtog_reg <= 1'b0;
      wreq_reg <= '0;
      rreq_reg <= '0;
    end else begin
      if (lst_reg == L_WDATA && cnt_reg == 4'hf) begin
        wtog_reg <= ~wtog_reg;
        wreq_reg <= '{space: ptr_reg[`SOP_CFG_BIT], widx: ptr_reg[4:1],
                      data: {prog_data_pin_in, sh_reg[15:1]}};
      end
      if (fetch_end && tbl_op && !wr_op) begin
        rtog_reg <= ~rtog_reg;
        rreq_reg <= '{space: ptr_pre[`SOP_CFG_BIT], widx: ptr_pre[4:1],
                      odd: ptr_pre[0]};
      end
    end
  end

  // Read-out on the data pin; the returned byte is stable once acknowledged.
  always_ff @(posedge prog_clock_pin_in) begin
    if (lrst_reg) begin
      latch_reg <= 8'h00;
      dout_reg  <= 1'b0;
      doe_reg   <= 1'b0;
    end else if (lst_reg == L_REXEC && cnt_reg == 4'h7) begin
      latch_reg <= (rack_s == rtog_reg) ? rd_byte_reg : 8'hff;
      dout_reg  <= (rack_s == rtog_reg) ? rd_byte_reg[0] : 1'b1;
      doe_reg   <= 1'b1;
    end else if (lst_reg == L_ROUT) begin
      dout_reg <= latch_reg[cnt_reg[2:0] + 3'h1];
      doe_reg  <= cnt_reg != 4'h7;
    end
  end

  assign prog_data_pin_out    = dout_reg;
  assign prog_data_pin_oe_out = doe_reg;

  // System domain, clocked by the system clock.
  logic      ck_meta, ck_s;
  logic      w_meta, w_s, r_meta, r_s;
  sop_wreq_t buf_reg [2];
  logic      bwp_reg, brp_reg;
  logic [1:0] bcnt_reg;
  logic      push, pop, push_rdy, pop_vld, commit;
  sop_pst_t  pst_reg;
  logic [10:0] pcnt_reg;
  sop_wreq_t cur_reg;
  logic [15:0] mem_reg [32];
  logic      act_reg, dis_reg;

  always_ff @(posedge clk_sys_in) begin
    ck_meta <= prog_clock_pin_in;
    ck_s    <= ck_meta;
    w_meta  <= wtog_reg;
    w_s     <= w_meta;
    r_meta  <= rtog_reg;
    r_s     <= r_meta;
  end

  assign push_rdy = bcnt_reg != 2'h2;
  assign pop_vld  = bcnt_reg != 2'h0;
  assign push     = (w_s != wack_reg) && push_rdy;
  assign pop      = pop_vld && pst_reg == P_IDLE && ck_s;
  assign commit   = pst_reg == P_PROG && !ck_s &&
                    pcnt_reg == 11'(`SOP_PROG_CYC);

  // Two-entry write buffer; a full buffer withholds the acknowledge, which
  // refuses further writes at the link until room appears.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wack_reg <= 1'b0;
      bwp_reg  <= 1'b0;
      brp_reg  <= 1'b0;
      bcnt_reg <= 2'h0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end else begin
      if (push) begin
        buf_reg[bwp_reg] <= wreq_reg;
        bwp_reg  <= ~bwp_reg;
        wack_reg <= w_s;
      end
      if (pop)
        brp_reg <= ~brp_reg;
      bcnt_reg <= bcnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rack_reg    <= 1'b0;
      rd_byte_reg <= 8'h00;
    end else if (r_s != rack_reg) begin
      rd_byte_reg <= rreq_reg.odd ? mem_reg[{rreq_reg.space, rreq_reg.widx}][15:8]
                                  : mem_reg[{rreq_reg.space, rreq_reg.widx}][7:0];
      rack_reg <= r_s;
    end
  end

  // A word is committed only if the clock pin stayed high for the full
  // programming time; a shorter pulse leaves the cell unchanged.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pst_reg  <= P_IDLE;
      pcnt_reg <= 11'h000;
      cur_reg  <= '0;
    end else begin
      case (pst_reg)
        P_IDLE: begin
          pcnt_reg <= 11'h000;
          if (pop) begin
            cur_reg <= buf_reg[brp_reg];
            pst_reg <= P_PROG;
          end
        end
        P_PROG: begin
          if (pcnt_reg != 11'(`SOP_PROG_CYC))
            pcnt_reg <= pcnt_reg + 11'h1;
          if (!ck_s) begin
            pcnt_reg <= 11'h000;
            pst_reg  <= P_DIS;
          end
        end
        P_DIS: begin
          pcnt_reg <= pcnt_reg + 11'h1;
          if (ck_s || pcnt_reg == 11'(`SOP_DIS_CYC - 1))
            pst_reg <= P_IDLE;
        end
        default: pst_reg <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      for (int i = 0; i < 32; i++)
        mem_reg[i] <= `SOP_ERASED;
    end else if (commit)
      mem_reg[{cur_reg.space, cur_reg.widx}] <= cur_reg.data;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      act_reg <= 1'b0;
      dis_reg <= 1'b0;
    end else begin
      act_reg <= pst_reg == P_PROG;
      dis_reg <= pst_reg == P_DIS;
    end
  end

  assign prog_active_out  = act_reg;
  assign hv_discharge_out = dis_reg;

  // Checks on the link and system sides.
  sequence s_out8;
    doe_reg [*8] ##1 !doe_reg;
  endsequence
  sequence s_fetch4;
    (lst_reg == L_FETCH) [*4];
  endsequence

  a_rd_eight_bits: assert property (@(posedge prog_clock_pin_in) disable iff (lrst_reg)
    $rose(doe_reg) |-> s_out8) else $error("read-out not eight bits");
  a_rd_lsb_first: assert property (@(posedge prog_clock_pin_in) disable iff (lrst_reg)
    lst_reg == L_ROUT |-> dout_reg == latch_reg[cnt_reg[2:0]])
    else $error("read-out bit order wrong");
  a_pin_release: assert property (@(posedge prog_clock_pin_in) disable iff (lrst_reg)
    lst_reg == L_ROUT && cnt_reg == 4'h7 |=> !doe_reg) else $error("pin not released");
  a_next_fetch: assert property (@(posedge prog_clock_pin_in) disable iff (lrst_reg)
    lst_reg == L_ROUT && cnt_reg == 4'h7 |=> s_fetch4) else $error("fetch not four clocks");
  a_rd_post_dec: assert property (@(posedge prog_clock_pin_in) disable iff (lrst_reg)
    lst_reg == L_REXEC && cnt_reg == 4'h7 && op_reg[1:0] == `SOP_MODE_DEC
    |=> ptr_reg == $past(ptr_reg) - 22'h1) else $error("post-decrement wrong");
  a_rd_ptr_kept: assert property (@(posedge prog_clock_pin_in) disable iff (lrst_reg)
    lst_reg == L_REXEC && cnt_reg == 4'h7 && op_reg[1:0] == `SOP_MODE_NONE
    |=> $stable(ptr_reg)) else $error("plain read moved pointer");
  a_cfg_space_sel: assert property (@(posedge prog_clock_pin_in) disable iff (lrst_reg)
    lst_reg == L_WDATA && cnt_reg == 4'hf
    |=> wreq_reg.space == $past(ptr_reg[21])) else $error("space select wrong");
  a_buf_push_word: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    push && !pop |=> bcnt_reg == $past(bcnt_reg) + 2'h1) else $error("write not buffered");
  a_word_commit: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    commit |=> mem_reg[{cur_reg.space, cur_reg.widx}] == cur_reg.data)
    else $error("word not committed");
  a_prog_held_high: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    pst_reg == P_PROG && ck_s |=> pst_reg == P_PROG) else $error("programming cut short");
  a_hv_discharge: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    pst_reg == P_PROG && !ck_s |-> ##2 hv_discharge_out) else $error("no discharge");
endmodule // sop_core

// >>> common/sop_cfg.svh
// Constants for the serial one-time-programmable program and verify engine.
`ifndef SOP_CFG_SVH
`define SOP_CFG_SVH
`define SOP_OP_LDL     4'h1
`define SOP_OP_LDH     4'h2
`define SOP_OP_LDU     4'h3
`define SOP_OP_TBL_BIT 3
`define SOP_OP_WR_BIT  2
`define SOP_MODE_NONE  2'h0
`define SOP_MODE_INC   2'h1
`define SOP_MODE_DEC   2'h2
`define SOP_MODE_PRE   2'h3
`define SOP_CFG_BIT    21
`define SOP_ERASED     16'hffff
`define SOP_PROG_NS    100000
`define SOP_SYS_NS     50
`define SOP_PROG_CYC   ((`SOP_PROG_NS + `SOP_SYS_NS - 1) / `SOP_SYS_NS)
`define SOP_DIS_CYC    4
`endif

// >>> common/sop_pkg.sv
// Types shared by the serial program and verify engine.
package sop_pkg;
  typedef enum logic [2:0] {L_FETCH, L_LOAD, L_WDATA, L_REXEC, L_ROUT} sop_lst_t;
  typedef enum logic [1:0] {P_IDLE, P_PROG, P_DIS} sop_pst_t;
  typedef struct packed {
    logic        space;
    logic [3:0]  widx;
    logic [15:0] data;
  } sop_wreq_t;
  typedef struct packed {
    logic       space;
    logic [3:0] widx;
    logic       odd;
  } sop_rreq_t;
endpackage

// >>> testbench/sop_prog_model.sv
// Behavioural programmer that drives the serial clock and data pins.
`timescale 1ns/1ps
module sop_prog_model (
  input  wire logic data_pin_in,
  output logic      clk_pin_out,
  output logic      drv_out
);
  localparam int HALF = 24;

  // The clock idles low between frames.
  initial begin
    clk_pin_out = 1'b0;
    drv_out     = 1'b0;
  end

  task automatic pulse(input logic b);
    drv_out = b;
    #HALF clk_pin_out = 1'b1;
    #HALF clk_pin_out = 1'b0;
  endtask

  task automatic op(input logic [3:0] c);
    for (int i = 0; i < 4; i++) begin
      pulse(c[i]);
    end
  endtask

  task automatic load(input logic [3:0] c, input logic [7:0] b);
    op(c);
    for (int i = 0; i < 8; i++) begin
      pulse(b[i]);
    end
  endtask

  // The last data bit leaves the clock high, so programming runs until drop.
  task automatic wr_begin(input logic [1:0] m, input logic [15:0] w);
    op({2'b11, m});
    for (int i = 0; i < 15; i++) begin
      pulse(w[i]);
    end
    drv_out = w[15];
    #HALF clk_pin_out = 1'b1;
  endtask

  // The drop waits half a period so it never lands on a system clock edge.
  task automatic drop();
    #HALF clk_pin_out = 1'b0;
  endtask

  // While released the drive toggles, so a stale level is never mistaken for data.
  task automatic rd(input logic [1:0] m, output logic [7:0] q);
    op({2'b10, m});
    for (int i = 0; i < 15; i++) begin
      drv_out = ~drv_out;
      #HALF clk_pin_out = 1'b1;
      #HALF clk_pin_out = 1'b0;
      if (i >= 7) begin
        q[i-7] = data_pin_in;
      end
    end
  endtask
endmodule  // sop_prog_model

// >>> testbench/tb_serial_otp_program_verify.sv
// Self-checking bench for the serial program and verify engine.
`timescale 1ns/1ps
`include "sop_cfg.svh"
module tb_serial_otp_program_verify;
  logic clk_sys_in;
  logic reset_in;
  logic prog_clk;
  logic drv;
  logic pin;
  logic dout;
  logic oe;
  logic active;
  logic hv;
  int   err_count;
  int   num_checks;

  assign pin = oe ? dout : drv;

  sop_core dut (
    .clk_sys_in           (clk_sys_in),
    .reset_in             (reset_in),
    .prog_clock_pin_in    (prog_clk),
    .prog_data_pin_in     (pin),
    .prog_data_pin_out    (dout),
    .prog_data_pin_oe_out (oe),
    .prog_active_out      (active),
    .hv_discharge_out     (hv)
  );

  sop_prog_model prog (
    .data_pin_in (pin),
    .clk_pin_out (prog_clk),
    .drv_out     (drv)
  );

  initial clk_sys_in = 1'b0;
  always #25 clk_sys_in = ~clk_sys_in;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic set_ptr(input logic [7:0] u, input logic [7:0] h, input logic [7:0] l);
    prog.load(`SOP_OP_LDU, u);
    prog.load(`SOP_OP_LDH, h);
    prog.load(`SOP_OP_LDL, l);
  endtask

  task automatic prog_word(input logic [1:0] m, input logic [15:0] w);
    int n;
    prog.wr_begin(m, w);
    repeat (20) @(posedge clk_sys_in);
    check({15'h0, active}, 16'h1);
    repeat (2100) @(posedge clk_sys_in);
    prog.drop();
    n = 0;
    while (hv !== 1'b1 && n < 8) begin
      @(posedge clk_sys_in);
      n++;
    end
    check({15'h0, hv}, 16'h1);
    repeat (20) @(posedge clk_sys_in);
    check({15'h0, hv}, 16'h0);
    check({15'h0, active}, 16'h0);
  endtask

  // The eighth read-out clock ends the drive; a nop then fills the next four clocks.
  task automatic rd_chk(input logic [1:0] m, input logic [7:0] exp);
    logic [7:0] q;
    prog.rd(m, q);
    check({8'h0, q}, {8'h0, exp});
    check({15'h0, oe}, 16'h1);
    prog.pulse(1'b0);
    check({15'h0, oe}, 16'h0);
    prog.op(4'h0);
  endtask

  task automatic t_program_verify();
    set_ptr(8'h00, 8'h00, 8'h01);
    prog_word(`SOP_MODE_NONE, 16'h3a5c);
    rd_chk(`SOP_MODE_DEC, 8'h3a);
    rd_chk(`SOP_MODE_NONE, 8'h5c);
    rd_chk(`SOP_MODE_NONE, 8'h5c);
    repeat (3) prog_word(`SOP_MODE_NONE, 16'h3a5c);
    rd_chk(`SOP_MODE_INC, 8'h5c);
    rd_chk(`SOP_MODE_NONE, 8'h3a);
  endtask

  task automatic t_rewrite();
    prog_word(`SOP_MODE_NONE, 16'h1234);
    rd_chk(`SOP_MODE_DEC, 8'h12);
    rd_chk(`SOP_MODE_NONE, 8'h34);
  endtask

  task automatic t_config_space();
    set_ptr(8'h03, 8'h00, 8'h00);
    prog_word(`SOP_MODE_PRE, 16'h6b27);
    rd_chk(`SOP_MODE_DEC, 8'h6b);
    rd_chk(`SOP_MODE_NONE, 8'h27);
    set_ptr(8'h00, 8'h00, 8'h01);
    rd_chk(`SOP_MODE_DEC, 8'h12);
    rd_chk(`SOP_MODE_NONE, 8'h34);
  endtask

  // An untouched word must still read as erased.
  task automatic t_erased();
    set_ptr(8'h00, 8'h00, 8'h0a);
    rd_chk(`SOP_MODE_NONE, 8'hff);
  endtask

  initial begin
    err_count = 0;
    num_checks = 0;
    reset_in = 1'b1;
    fork
      repeat (4) prog.pulse(1'b0);
    join_none
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    // Two edges flush the link-side reset copy; a third would shift a bit in.
    repeat (2) prog.pulse(1'b0);
    t_program_verify();
    t_rewrite();
    t_config_space();
    t_erased();
    test_done();
  end

  initial begin
    #3000000;
    err_count++;
    test_done();
  end
endmodule  // tb_serial_otp_program_verify
